/* File: hdl/led_prot_pkg.sv */
// package: constants, types and register map of the led protection block
// assumes one 250 MHz system clock and a simple strobe register port
package led_prot_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned DETECT_MIN_NS    = 8000;
  localparam int unsigned DETECT_CYC       = (DETECT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RETRY_INTERVAL_US = 10000;
  localparam int unsigned RETRY_CYC        = RETRY_INTERVAL_US * CLK_MHZ;
  localparam int unsigned STEP_PERIOD_US   = 1000000;
  localparam int unsigned STEP_CYC         = STEP_PERIOD_US * CLK_MHZ;
  localparam int unsigned WAKE_DOM_NS      = 150000;
  localparam int unsigned WAKE_CYC         = WAKE_DOM_NS * CLK_MHZ / 1000;
  localparam int unsigned RETRY_COUNT      = 20;

  // register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_COLOR  = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_FULL   = 4'h3;
  localparam logic [3:0] REG_CMD    = 4'h4;

  // control field positions
  localparam int unsigned CTRL_ALL_ON  = 0;
  localparam int unsigned CTRL_EN_LSB  = 1;
  localparam int unsigned CTRL_TREG    = 4;
  localparam int unsigned CTRL_SCOPE   = 5;
  localparam logic [7:0]  CTRL_RESET   = 8'h0F;

  // colour command: byte 5 holds the mode in bits 7:6
  localparam int unsigned MODE_LSB = 6;

  // command register code for go-to-sleep
  localparam logic [7:0] CMD_SLEEP = 8'h3C;

  typedef enum logic [1:0] {
    UPD_NOW    = 2'b00,
    UPD_STORE  = 2'b01,
    UPD_STORED = 2'b10,
    UPD_DROP   = 2'b11
  } color_update_mode_t;

  typedef enum logic [2:0] {
    ERR_NONE  = 3'b000,
    ERR_GND   = 3'b010,
    ERR_SENSE = 3'b011,
    ERR_OPEN  = 3'b101
  } channel_error_code_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic open_led;
    logic short_led;
    logic gnd_short;
    logic sense_open;
  } fault_in_t;

endpackage

/* File: hdl/led_protection_retry_ctrl.sv */
// protection, retry, thermal and sleep control for a three-channel driver
// assumes fault and thermal comparators plus lin line are async pins
// Overview of operation
// - mode 00 apply, 01 store, 10 stored, 11 drop
// - mode lives in byte 5 bits 7:6
// - record 3-bit error code per channel
// - codes 000, 011, 010, 101 as listed
// - open/short/sense need 8 us on time
// - ground short: output off, bias zero
// - open leds keep leds on, short leds switch off
// - sticky warning flag on warning temperature
// - shutdown: leds off, sticky, resume below warning
// - regulation: one step down, level increments
// - each period step again if warning persists
// - all-on write restores currents, level zero
// - retry eligible error sets retry active
// - each interval retry on for one cycle, then off again until a full-status read clears the code
// - full-status read clears counter and flags
// - one shared timer, new error restarts it only while an eligible error is already stored
// - twenty attempts after each full-status read
// - scope bit: all leds or failing only
// - sleep: leds off, bias zero, registers reset
// - wake after dominant longer than wake time
// - go-to-sleep frame enters sleep
// - all-on switch and enables, no on in ground or sense error outside retry attempts
module led_protection_retry_ctrl
  import led_prot_pkg::*;
#(
  parameter int unsigned CH        = 3,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned STEP_CYCLES  = STEP_CYC,
  parameter int unsigned WAKE_CYCLES  = WAKE_CYC
)(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_ce,
  // register port
  input  wire led_prot_pkg::reg_req_t i_req,
  output logic [7:0]                 o_rdata,
  // analog sense pins
  input  wire led_prot_pkg::fault_in_t [CH-1:0] i_fault,
  input  wire logic                  i_temp_warn,
  input  wire logic                  i_temp_sd,
  input  wire logic                  i_lin_rx,
  // outputs
  output logic [CH-1:0]              o_led_cathode_output,
  output logic                       o_ballast_bias_output,
  output logic [3:0]                 o_thermal_reduction_level,
  output logic [3:0]                 o_thermal_current_step,
  output logic [7:0]                 o_color_applied,
  output logic                       o_sleep
);

  import led_prot_pkg::*;

  // synchronisers
  logic [4*CH+2:0] s1_r, s2_r;
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else if (i_ce)
    begin
      s1_r <= {i_lin_rx, i_temp_sd, i_temp_warn, i_fault};
      s2_r <= s1_r;
    end
  end
  fault_in_t [CH-1:0] flt;
  logic tw, thermal_shutdown_flag, lin;
  assign {lin, thermal_shutdown_flag, tw, flt} = s2_r;

  logic       sleep_r;
  logic       srst;
  assign srst = !i_nrst || sleep_r;

  logic [7:0] ctrl_r;
  logic [7:0] stored_r, applied_r;
  logic       full_rd;
  logic       sleep_cmd;
  assign full_rd   = i_req.rd && i_req.addr == REG_FULL;
  assign sleep_cmd = i_req.wr && i_req.addr == REG_CMD
                     && i_req.wdata == CMD_SLEEP;

  // control register
  always_ff @(posedge i_clk)
  begin
    if (srst)
      ctrl_r <= CTRL_RESET;
    else if (i_ce && i_req.wr && i_req.addr == REG_CTRL)
      ctrl_r <= i_req.wdata;
  end

  // colour update modes
  color_update_mode_t mode;
  assign mode = color_update_mode_t'(i_req.wdata[MODE_LSB+:2]);
  always_ff @(posedge i_clk)
  begin
    if (srst)
    begin
      stored_r  <= '0;
      applied_r <= '0;
    end
    else if (i_ce && i_req.wr && i_req.addr == REG_COLOR)
    begin
      unique case (mode)
        UPD_NOW:    applied_r <= {2'b00, i_req.wdata[5:0]};
        UPD_STORE:  stored_r  <= {2'b00, i_req.wdata[5:0]};
        UPD_STORED: applied_r <= stored_r;
        UPD_DROP:   ;
      endcase
    end
  end
  assign o_color_applied = applied_r;

  // per-channel detection and error codes
  logic [CH-1:0] led_on, elig, new_err, gnd_err;
  channel_error_code_t code_r [CH];
  logic [13:0] on_cnt_r [CH];
  genvar g;
  generate
    for (g = 0; g < CH; g++)
    begin : g_ch
      logic long_on;
      assign long_on = on_cnt_r[g] >= 14'(DETECT_CYC);
      always_ff @(posedge i_clk)
      begin
        if (srst)
          on_cnt_r[g] <= '0;
        else if (i_ce)
        begin
          if (!led_on[g])
            on_cnt_r[g] <= '0;
          else if (!long_on)
            on_cnt_r[g] <= on_cnt_r[g] + 14'h0001;
        end
      end
      channel_error_code_t det;
      always_comb
      begin
        det = ERR_NONE;
        if (flt[g].gnd_short)
          det = ERR_GND;
        else if (long_on && (flt[g].sense_open || flt[g].short_led))
          det = ERR_SENSE;
        else if (long_on && flt[g].open_led)
          det = ERR_OPEN;
      end
      assign new_err[g] = det != ERR_NONE && code_r[g] == ERR_NONE;
      always_ff @(posedge i_clk)
      begin
        if (srst)
          code_r[g] <= ERR_NONE;
        else if (i_ce)
        begin
          if (new_err[g])
            code_r[g] <= det;
          else if (full_rd)
            code_r[g] <= ERR_NONE;
        end
      end
      assign gnd_err[g] = code_r[g] == ERR_GND;
      assign elig[g] = code_r[g] == ERR_GND || code_r[g] == ERR_SENSE;
    end
  endgenerate

  // thermal flags
  logic tw_flag_r, tsd_flag_r, tsd_act_r;
  always_ff @(posedge i_clk)
  begin
    if (srst)
    begin
      tw_flag_r  <= 1'b0;
      tsd_flag_r <= 1'b0;
      tsd_act_r  <= 1'b0;
    end
    else if (i_ce)
    begin
      if (tw)
        tw_flag_r <= 1'b1;
      else if (full_rd)
        tw_flag_r <= 1'b0;
      if (thermal_shutdown_flag)
        tsd_flag_r <= 1'b1;
      else if (full_rd)
        tsd_flag_r <= 1'b0;
      if (thermal_shutdown_flag)
        tsd_act_r <= 1'b1;
      else if (!tw)
        tsd_act_r <= 1'b0;
    end
  end

  // thermal regulation
  logic [3:0]  lvl_r;
  logic [31:0] step_cnt_r;
  logic        reg_on;
  logic        restore;
  assign reg_on  = ctrl_r[CTRL_TREG];
  assign restore = i_req.wr && i_req.addr == REG_CTRL
                   && i_req.wdata[CTRL_ALL_ON];
  always_ff @(posedge i_clk)
  begin
    if (srst)
    begin
      lvl_r      <= '0;
      step_cnt_r <= '0;
    end
    else if (i_ce)
    begin
      if (restore)
      begin
        lvl_r      <= '0;
        step_cnt_r <= '0;
      end
      else if (lvl_r == 4'h0)
      begin
        if (reg_on && tw)
          lvl_r <= 4'h1;
      end
      else if (step_cnt_r == 32'(STEP_CYCLES - 1))
      begin
        step_cnt_r <= '0;
        if (tw && lvl_r != 4'hF)
          lvl_r <= lvl_r + 4'h1;
      end
      else
        step_cnt_r <= step_cnt_r + 32'h0000_0001;
    end
  end
  assign o_thermal_reduction_level = lvl_r;
  assign o_thermal_current_step    = lvl_r;

  // retry machine with one shared interval timer
  typedef enum logic [1:0] {RT_IDLE, RT_WAIT, RT_TRY, RT_DONE} rt_t;
  rt_t         rt_r;
  logic [31:0] rt_cnt_r;
  logic [4:0]  tries_r;
  logic        any_elig;
  assign any_elig = |elig;
  always_ff @(posedge i_clk)
  begin
    if (srst)
    begin
      rt_r     <= RT_IDLE;
      rt_cnt_r <= '0;
      tries_r  <= '0;
    end
    else if (i_ce)
    begin
      if (full_rd)
      begin
        rt_r    <= RT_IDLE;
        tries_r <= '0;
      end
      else if (|new_err && any_elig)
      begin
        rt_cnt_r <= '0;
        if (rt_r == RT_IDLE || rt_r == RT_TRY)
          rt_r <= RT_WAIT;
      end
      else
      begin
        unique case (rt_r)
          RT_IDLE: if (any_elig) rt_r <= RT_WAIT;
          RT_WAIT:
            if (rt_cnt_r == 32'(RETRY_CYCLES - 1))
            begin
              rt_cnt_r <= '0;
              rt_r     <= RT_TRY;
              tries_r  <= tries_r + 5'h01;
            end
            else
              rt_cnt_r <= rt_cnt_r + 32'h0000_0001;
          RT_TRY:
            rt_r <= (tries_r == 5'(RETRY_COUNT)) ? RT_DONE : RT_WAIT;
          RT_DONE: ;
        endcase
      end
    end
  end
  logic retry_active;
  assign retry_active = rt_r != RT_IDLE;

  // output gating
  logic [CH-1:0] block;
  logic          any_gnd;
  assign any_gnd = |gnd_err;
  always_comb
  begin
    block = elig;
    if (ctrl_r[CTRL_SCOPE] && any_elig)
      block = '1;
    if (rt_r == RT_TRY)
      block = '0;
  end
  assign led_on = {CH{ctrl_r[CTRL_ALL_ON] && !tsd_act_r && !sleep_r}}
                  & ctrl_r[CTRL_EN_LSB+:CH] & ~block;
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_led_cathode_output  <= '0;
      o_ballast_bias_output <= 1'b0;
    end
    else if (i_ce)
    begin
      o_led_cathode_output  <= led_on;
      o_ballast_bias_output <= !sleep_r && !tsd_act_r
                               && !(any_gnd && rt_r != RT_TRY);
    end
  end

  // sleep entry and wake
  logic [31:0] wake_cnt_r;
  logic        lin_prev_r, armed_r;
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      sleep_r    <= 1'b0;
      wake_cnt_r <= '0;
      lin_prev_r <= 1'b1;
      armed_r    <= 1'b0;
    end
    else if (i_ce)
    begin
      lin_prev_r <= lin;
      if (!sleep_r)
      begin
        armed_r    <= 1'b0;
        wake_cnt_r <= '0;
        if (sleep_cmd)
          sleep_r <= 1'b1;
      end
      else if (lin_prev_r && !lin)
      begin
        armed_r    <= 1'b1;
        wake_cnt_r <= '0;
      end
      else if (armed_r && !lin)
      begin
        if (wake_cnt_r >= 32'(WAKE_CYCLES))
          sleep_r <= 1'b0;
        else
          wake_cnt_r <= wake_cnt_r + 32'h0000_0001;
      end
      else
        armed_r <= 1'b0;
    end
  end
  assign o_sleep = sleep_r;

  // read data
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_rdata <= '0;
    else if (i_ce)
    begin
      o_rdata <= '0;
      if (i_req.rd)
      begin
        unique case (i_req.addr)
          REG_CTRL:  o_rdata <= ctrl_r;
          REG_COLOR: o_rdata <= applied_r;
          REG_STATUS, REG_FULL:
            o_rdata <= {retry_active, tsd_flag_r, tw_flag_r, 1'b0, lvl_r};
          default:   o_rdata <= {code_r[2][1:0], code_r[1], code_r[0]};
        endcase
      end
    end
  end

  // checks
  chk_sleep_dark: assert property (@(posedge i_clk) disable iff (!i_nrst)
    sleep_r && i_ce |=> o_led_cathode_output == '0)
    else $error("leds lit during sleep");
  chk_bias_gnd: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_ce && any_gnd && rt_r == RT_WAIT |=> !o_ballast_bias_output)
    else $error("bias on with ground short");
  chk_tsd_off: assert property (@(posedge i_clk) disable iff (srst)
    tsd_act_r |-> led_on == '0)
    else $error("leds on in shutdown");
  chk_level_sat: assert property (@(posedge i_clk) disable iff (srst)
    i_ce && lvl_r == 4'hF && !restore |=> lvl_r == 4'hF)
    else $error("reduction level wrapped");
  chk_restore_zero: assert property (@(posedge i_clk) disable iff (srst)
    i_ce && restore |=> lvl_r == 4'h0)
    else $error("level not cleared");
  chk_full_clear: assert property (@(posedge i_clk) disable iff (srst)
    i_ce && full_rd |=> rt_r == RT_IDLE && tries_r == 5'h00)
    else $error("retry not cleared");
  chk_tries_max: assert property (@(posedge i_clk) disable iff (srst)
    tries_r <= 5'(RETRY_COUNT))
    else $error("too many attempts");
  chk_drop_mode: assert property (@(posedge i_clk) disable iff (srst)
    i_ce && i_req.wr && i_req.addr == REG_COLOR && mode == UPD_DROP
    |=> $stable(applied_r) && $stable(stored_r))
    else $error("discard mode changed colour");
  cov_retry: cover property (@(posedge i_clk) rt_r == RT_TRY);
  cov_done: cover property (@(posedge i_clk) rt_r == RT_DONE);
  cov_sleep_wake: cover property (@(posedge i_clk) $fell(sleep_r));

endmodule // led_protection_retry_ctrl

/* File: tb/lin_master_model.sv */
// partner: master issuing commands and status reads on the register port
// assumes rd data stand only in the cycle after the read strobe
module lin_master_model
  import led_prot_pkg::*;
(
  // clock
  input  wire logic                  i_clk,
  // register port
  output led_prot_pkg::reg_req_t     o_req,
  input  wire logic [7:0]            i_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_req = '0;
  // one write cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    o_req <= '0;
  endtask
  // one read cycle, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    o_req <= '0;
    #1 d = i_rdata;
  endtask
  // colour command: mode in bits 7:6
  task automatic color(input logic [1:0] m, input logic [5:0] v);
    wr(REG_COLOR, {m, v});
  endtask
endmodule // lin_master_model

/* File: tb/led_protection_retry_ctrl_test.sv */
// testbench: protection, retry, thermal and sleep scenarios
// assumes short counts: retry 20, step 30, wake 10 cycles
module led_protection_retry_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  import led_prot_pkg::*;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  reg_req_t              req;
  logic [7:0]            rdata;
  fault_in_t [2:0]       fault = '0;
  logic                  warn = 1'b0;
  logic                  sd = 1'b0;
  logic                  lin = 1'b1;
  logic [2:0]            led;
  logic                  bias;
  logic [3:0]            lvl;
  logic [3:0]            stp;
  logic [7:0]            col;
  logic                  slp;
  logic [7:0]            d;
  int                    fails = 0;
  int                    n_tests = 0;
  int                    cyc = 0;
  always #2 clk = ~clk;
  lin_master_model i_lin_master_model (
    .i_clk   (clk),
    .o_req   (req),
    .i_rdata (rdata)
  );
  led_protection_retry_ctrl #(
    .RETRY_CYCLES (20),
    .STEP_CYCLES  (30),
    .WAKE_CYCLES  (10)
  ) i_led_protection_retry_ctrl (
    .i_clk                     (clk),
    .i_nrst                    (nrst),
    .i_ce                      (1'b1),
    .i_req                     (req),
    .o_rdata                   (rdata),
    .i_fault                   (fault),
    .i_temp_warn               (warn),
    .i_temp_sd                 (sd),
    .i_lin_rx                  (lin),
    .o_led_cathode_output      (led),
    .o_ballast_bias_output     (bias),
    .o_thermal_reduction_level (lvl),
    .o_thermal_current_step    (stp),
    .o_color_applied           (col),
    .o_sleep                   (slp)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic results;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    i_lin_master_model.rd(REG_CTRL, d);
    chk(d, CTRL_RESET);
    wt(5);
    chk({5'h0, led}, 8'h07);
    $display("test reset done");
  endtask
  task automatic t_color;
    i_lin_master_model.color(UPD_STORE, 6'h15);
    wt(3);
    chk({2'b0, col[5:0]}, 8'h00);
    i_lin_master_model.color(UPD_STORED, 6'h00);
    wt(3);
    chk({2'b0, col[5:0]}, 8'h15);
    i_lin_master_model.color(UPD_NOW, 6'h2A);
    wt(3);
    chk({2'b0, col[5:0]}, 8'h2A);
    i_lin_master_model.color(UPD_DROP, 6'h01);
    wt(3);
    chk({2'b0, col[5:0]}, 8'h2A);
    $display("test color done");
  endtask
  task automatic t_thermal;
    i_lin_master_model.wr(REG_CTRL, 8'h1F);
    warn <= 1'b1;
    wt(8);
    chk({4'h0, lvl}, 8'h01);
    wt(40);
    chk({4'h0, lvl}, 8'h02);
    wt(600);
    chk({4'h0, lvl}, 8'h0F);
    chk({4'h0, stp}, 8'h0F);
    warn <= 1'b0;
    wt(70);
    d = {4'h0, lvl};
    wt(20);
    chk({4'h0, lvl}, d);
    i_lin_master_model.rd(REG_STATUS, d);
    chk(d, 8'h2F);
    i_lin_master_model.wr(REG_CTRL, 8'h1F);
    wt(3);
    chk({4'h0, lvl}, 8'h00);
    $display("test thermal done");
  endtask
  task automatic t_shutdown;
    sd <= 1'b1;
    warn <= 1'b1;
    wt(6);
    chk({5'h0, led}, 8'h00);
    sd <= 1'b0;
    wt(6);
    chk({5'h0, led}, 8'h00);
    warn <= 1'b0;
    wt(6);
    chk({5'h0, led}, 8'h07);
    i_lin_master_model.rd(REG_FULL, d);
    i_lin_master_model.rd(REG_STATUS, d);
    chk(d & 8'h40, 8'h00);
    $display("test shutdown done");
  endtask
  task automatic t_fault;
    fault[1].gnd_short <= 1'b1;
    wt(6);
    chk({5'h0, led}, 8'h05);
    chk({7'h0, bias}, 8'h00);
    i_lin_master_model.rd(REG_STATUS, d);
    chk(d & 8'h80, 8'h80);
    i_lin_master_model.rd(4'hF, d);
    chk({5'h0, d[5:3]}, {5'h0, ERR_GND});
    fault[1].gnd_short <= 1'b0;
    wt(60);
    chk({5'h0, led}, 8'h05);
    i_lin_master_model.rd(REG_FULL, d);
    wt(60);
    chk({5'h0, led}, 8'h07);
    i_lin_master_model.rd(REG_STATUS, d);
    // level 1 from the shutdown test is held until an all-on write
    chk(d, 8'h01);
    i_lin_master_model.wr(REG_CTRL, 8'h3F);
    fault[0].gnd_short <= 1'b1;
    wt(6);
    chk({5'h0, led}, 8'h00);
    fault[0].gnd_short <= 1'b0;
    i_lin_master_model.rd(REG_FULL, d);
    $display("test fault done");
  endtask
  task automatic t_sleep;
    i_lin_master_model.wr(REG_CMD, CMD_SLEEP);
    wt(4);
    chk({7'h0, slp}, 8'h01);
    chk({4'h0, led, bias}, 8'h00);
    lin <= 1'b0;
    wt(6);
    lin <= 1'b1;
    wt(6);
    chk({7'h0, slp}, 8'h01);
    lin <= 1'b0;
    wt(20);
    lin <= 1'b1;
    wt(6);
    chk({7'h0, slp}, 8'h00);
    i_lin_master_model.rd(REG_CTRL, d);
    chk(d, CTRL_RESET);
    $display("test sleep done");
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    wt(10);
    nrst <= 1'b1;
    t_reset();
    t_color();
    t_thermal();
    t_shutdown();
    t_fault();
    t_sleep();
    results();
  end
endmodule // led_protection_retry_ctrl_test
